/* hw/spac_consts.svh */
// Purpose: Named constants for the serial port and rate clock block.
// Assumes: Included by bare name, definitions only.
// Notes:   Counts are in analog clock ticks, sample periods or serial bits.
`ifndef SPAC_CONSTS_SVH
`define SPAC_CONSTS_SVH

`define SPAC_CMD_LAST      3'h7
`define SPAC_CMD_READ_BIT  0
`define SPAC_PRE_DEFAULT   2'h0
`define SPAC_RATIO_DEFAULT 3'h3
`define SPAC_RATIO_BASE    13'h0020
`define SPAC_SAMPLE_LAST   2'h3
`define SPAC_DR_HALF_LAST  2'h1
`define SPAC_ONE3          3'h1
`define SPAC_ONE13         13'h0001

`endif

/* hw/spac_pkg.sv */
// Purpose: Types shared by the serial port and rate clock block.
// Assumes: Constants come from spac_consts.svh.
// Notes:   Command carrier pairs the raw word with its decode.
package spac_pkg;

    typedef enum logic [2:0] {
        SPAC_IDLE,
        SPAC_CMD,
        SPAC_READ,
        SPAC_WRITE,
        SPAC_FRAME
    } spac_state_t;

    typedef struct packed {
        logic [7:0] code;
        logic       is_read;
    } spac_cmd_t;

endpackage

/* hw/spac_top.sv */
// Purpose: Serial data pins and master/analog/sample/rate clock chain.
// Assumes: All pins sampled as synchronous to clock; edges found here.
// Notes:   Clocks leave as strobes or levels, never as real clocks.
// Operation
// (R1) Output line changes on falling serial clock edges while read data goes out.
// (R2) Output line undriven during the 8-bit command byte.
// (R3) Output undriven for writes, chip select high, or hardware reset low.
// (R4) Output driven only while a read command is processed.
// (R5) Link is half duplex; input and output never share clock periods.
// (R6) Two-wire mode: one frame per data-ready event, bits on falling edges.
// (R7) Input bits captured on rising serial clock edges.
// (R8) Host opens with chip select low then an 8-bit command.
// (R9) Each command word decodes as read or write.
// (R10) Input line ignored while chip select is high.
// (R11) Two-wire: input pin latched as upper ratio bit, entry and watchdog.
// (R12) Master clock from crystal, clock pin, or serial clock in two-wire.
// (R13) Analog clock is master clock divided by 1, 2, 4 or 8.
// (R14) Sample clock is analog clock divided by four.
// (R15) Modulator refreshed once per sample clock period.
// (R16) Rate clock is sample clock divided by oversampling ratio.
// (R17) One data-ready pulse per new result at the output rate; code gives none in two-wire mode.
// (R18) Ratio field 000 gives 32 up to 111 gives 4096, default 256.
// (R19) Data-ready pulse active low, master-clock timed, half a sample period.
// (R20) Mode pin latched after reset events: low SPI, high two-wire.
// (R21) Chip select fall starts, rise ends; nothing while hardware reset low.
// (R22) Data-ready events cross safely into serial-side logic.
`timescale 1ns/1ps
`include "spac_consts.svh"

module spac_top #(
    parameter int FRAME_W = 16
) (
    input  wire logic                  clock,
    input  wire logic                  reset,
    input  wire logic                  chip_select_n,
    input  wire logic                  serial_clock,
    input  wire logic                  serial_input_line,
    input  wire logic                  hw_reset_n,
    input  wire logic                  mode_select_pin,
    input  wire logic                  master_reset,
    input  wire logic                  watchdog_reset,
    input  wire logic                  external_clock_select,
    input  wire logic                  crystal_clock,
    input  wire logic                  clock_input_pin,
    input  wire logic [1:0]            prescale_field,
    input  wire logic [2:0]            ratio_select_field,
    input  wire logic [7:0]            read_byte,
    input  wire logic [FRAME_W-1:0]    frame_word,
    output logic                       serial_output_line,
    output logic                       serial_output_enable,
    output spac_pkg::spac_cmd_t        command,
    output logic                       command_valid,
    output logic                       read_request,
    output logic [7:0]                 write_byte,
    output logic                       write_strobe,
    output logic                       two_wire_mode,
    output logic                       ratio_select_upper_pin,
    output logic                       analog_clock,
    output logic                       sample_clock,
    output logic                       modulator_refresh,
    output logic                       output_rate_clock,
    output logic                       data_ready_output
);
    import spac_pkg::*;

    localparam int CW = $clog2(FRAME_W + 1);

    function automatic logic [12:0] ratio_of(input logic [2:0] sel);
        ratio_of = `SPAC_RATIO_BASE << sel; // (R18)
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Edge detection on sampled pins
    logic sck_q_reg, cs_q_reg, src_q_reg;
    logic src, mtick, sck_rise, sck_fall, cs_fall;

    always_comb begin
        src = two_wire_mode ? serial_clock : // (R12)
              (external_clock_select ? clock_input_pin : crystal_clock); // (R12)
        mtick    = src & ~src_q_reg;
        sck_rise = serial_clock & ~sck_q_reg;
        sck_fall = ~serial_clock & sck_q_reg;
        cs_fall  = ~chip_select_n & cs_q_reg;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sck_q_reg <= 1'b0;
            cs_q_reg  <= 1'b1;
            src_q_reg <= 1'b0;
        end else begin
            sck_q_reg <= serial_clock;
            cs_q_reg  <= chip_select_n;
            src_q_reg <= src;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Mode and strap latching
    logic strap_done_reg, strap_done_next;
    logic mode_next, upper_next;

    always_comb begin
        strap_done_next = 1'b1;
        mode_next       = two_wire_mode;
        upper_next      = ratio_select_upper_pin;
        // Strap caught after reset release
        if (!strap_done_reg || master_reset || watchdog_reset) begin
            mode_next = mode_select_pin; // (R20)
        end
        if ((mode_next && !two_wire_mode) || (mode_next && watchdog_reset)) begin
            upper_next = serial_input_line; // (R11)
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            strap_done_reg         <= 1'b0;
            two_wire_mode          <= 1'b0;
            ratio_select_upper_pin <= 1'b0;
        end else begin
            strap_done_reg         <= strap_done_next;
            two_wire_mode          <= mode_next;
            ratio_select_upper_pin <= upper_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Clock chain
    logic [2:0]  pre_cnt_reg, pre_cnt_next;
    logic [1:0]  am_cnt_reg, am_cnt_next;
    logic [12:0] rate_cnt_reg, rate_cnt_next;
    logic [1:0]  dr_cnt_reg, dr_cnt_next;
    logic        rate_tick_reg, rate_tick_next;
    logic        am_next, smp_next, rate_clk_next, dr_next, refresh_next;
    logic [2:0]  pre_last, eff_sel;
    logic [12:0] oversampling_ratio;
    logic        am_tick, smp_tick, rate_tick;

    always_comb begin
        pre_last = (`SPAC_ONE3 << prescale_field) - `SPAC_ONE3; // (R13)
        eff_sel  = two_wire_mode ?
                   {ratio_select_upper_pin, ratio_select_field[1:0]} : // (R11)
                   ratio_select_field;
        oversampling_ratio      = ratio_of(eff_sel);
        am_tick  = mtick && (pre_cnt_reg >= pre_last); // (R13)
        smp_tick = am_tick && (am_cnt_reg == `SPAC_SAMPLE_LAST); // (R14)
        rate_tick = smp_tick && (rate_cnt_reg >= oversampling_ratio - `SPAC_ONE13); // (R16)
        pre_cnt_next  = pre_cnt_reg;
        am_cnt_next   = am_cnt_reg;
        rate_cnt_next = rate_cnt_reg;
        if (mtick) begin
            pre_cnt_next = am_tick ? 3'h0 : pre_cnt_reg + `SPAC_ONE3;
        end
        if (am_tick) begin
            am_cnt_next = am_cnt_reg + 2'h1;
        end
        if (smp_tick) begin
            rate_cnt_next = rate_tick ? 13'h0000 : rate_cnt_reg + `SPAC_ONE13;
        end
        am_next        = am_tick;
        smp_next       = am_cnt_next[1];
        refresh_next   = smp_tick; // (R15)
        rate_clk_next  = rate_cnt_next < (oversampling_ratio >> 1);
        rate_tick_next = rate_tick;
        dr_next        = data_ready_output;
        dr_cnt_next    = dr_cnt_reg;
        if (rate_tick && !two_wire_mode) begin
            dr_next     = 1'b0; // (R17)
            dr_cnt_next = 2'h0;
        end else if (!data_ready_output && am_tick) begin
            // Two analog periods make half a sample period
            dr_cnt_next = dr_cnt_reg + 2'h1;
            if (dr_cnt_reg == `SPAC_DR_HALF_LAST) begin
                dr_next = 1'b1; // (R19)
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pre_cnt_reg       <= 3'h0;
            am_cnt_reg        <= 2'h0;
            rate_cnt_reg      <= 13'h0000;
            dr_cnt_reg        <= 2'h0;
            rate_tick_reg     <= 1'b0;
            analog_clock      <= 1'b0;
            sample_clock      <= 1'b0;
            modulator_refresh <= 1'b0;
            output_rate_clock <= 1'b0;
            data_ready_output <= 1'b1;
        end else begin
            pre_cnt_reg       <= pre_cnt_next;
            am_cnt_reg        <= am_cnt_next;
            rate_cnt_reg      <= rate_cnt_next;
            dr_cnt_reg        <= dr_cnt_next;
            rate_tick_reg     <= rate_tick_next;
            analog_clock      <= am_next;
            sample_clock      <= smp_next;
            modulator_refresh <= refresh_next;
            output_rate_clock <= rate_clk_next;
            data_ready_output <= dr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Serial port
    spac_state_t        state_reg, state_next;
    logic [2:0]         bit_reg, bit_next;
    logic [CW-1:0]      fcnt_reg, fcnt_next;
    logic [7:0]         in_reg, in_next;
    logic [FRAME_W-1:0] out_reg, out_next;
    logic               req_reg, req_next;
    logic               sdo_next, oe_next, cv_next, rr_next, ws_next;
    logic [7:0]         wb_next, word;
    spac_cmd_t          cmd_next;

    always_comb begin
        state_next = state_reg;
        bit_next   = bit_reg;
        fcnt_next  = fcnt_reg;
        in_next    = in_reg;
        out_next   = out_reg;
        sdo_next   = serial_output_line;
        oe_next    = serial_output_enable;
        cmd_next   = command;
        wb_next    = write_byte;
        cv_next    = 1'b0;
        rr_next    = 1'b0;
        ws_next    = 1'b0;
        word       = {in_reg[6:0], serial_input_line};
        // Event already in this domain; a set beats the take below
        req_next   = two_wire_mode && (req_reg || rate_tick_reg); // (R22)
        if (!hw_reset_n) begin
            state_next = SPAC_IDLE; // (R21)
            oe_next    = 1'b0; // (R3)
        end else if (two_wire_mode) begin
            case (state_reg)
                SPAC_FRAME: begin
                    if (sck_fall) begin
                        if (fcnt_reg == CW'(FRAME_W)) begin
                            oe_next    = 1'b0;
                            state_next = SPAC_IDLE;
                        end else begin
                            sdo_next  = out_reg[FRAME_W-1]; // (R6)
                            oe_next   = 1'b1; // (R6)
                            out_next  = out_reg << 1;
                            fcnt_next = fcnt_reg + CW'(1);
                        end
                    end
                end
                default: begin
                    oe_next = 1'b0;
                    if (req_reg) begin
                        state_next = SPAC_FRAME; // (R6)
                        out_next   = frame_word;
                        fcnt_next  = '0;
                        req_next   = rate_tick_reg;
                    end
                end
            endcase
        end else if (chip_select_n) begin
            state_next = SPAC_IDLE; // (R10)
            oe_next    = 1'b0; // (R3)
        end else begin
            case (state_reg)
                SPAC_IDLE: begin
                    oe_next = 1'b0;
                    if (cs_fall) begin
                        state_next = SPAC_CMD; // (R21)
                        bit_next   = 3'h0;
                    end
                end
                SPAC_CMD: begin
                    oe_next = 1'b0; // (R2)
                    if (sck_rise) begin
                        in_next  = word; // (R7)
                        bit_next = bit_reg + 3'h1;
                        if (bit_reg == `SPAC_CMD_LAST) begin
                            cv_next          = 1'b1;
                            cmd_next.code    = word;
                            cmd_next.is_read = word[`SPAC_CMD_READ_BIT]; // (R9)
                            if (word[`SPAC_CMD_READ_BIT]) begin
                                state_next = SPAC_READ;
                                out_next   = FRAME_W'(read_byte) << (FRAME_W - 8);
                                rr_next    = 1'b1;
                            end else begin
                                state_next = SPAC_WRITE;
                            end
                        end
                    end
                end
                SPAC_READ: begin
                    // Input ignored here: half duplex
                    if (sck_fall) begin
                        sdo_next = out_reg[FRAME_W-1]; // (R1)
                        oe_next  = 1'b1; // (R4)
                        bit_next = bit_reg + 3'h1;
                        if (bit_reg == `SPAC_CMD_LAST) begin
                            out_next = FRAME_W'(read_byte) << (FRAME_W - 8);
                            rr_next  = 1'b1;
                        end else begin
                            out_next = out_reg << 1;
                        end
                    end
                end
                SPAC_WRITE: begin
                    oe_next = 1'b0; // (R3)
                    if (sck_rise) begin
                        in_next  = word; // (R7)
                        bit_next = bit_reg + 3'h1;
                        if (bit_reg == `SPAC_CMD_LAST) begin
                            wb_next = word; // (R5)
                            ws_next = 1'b1;
                        end
                    end
                end
                default: begin
                    state_next = SPAC_IDLE;
                    oe_next    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_reg            <= SPAC_IDLE;
            bit_reg              <= 3'h0;
            fcnt_reg             <= '0;
            in_reg               <= 8'h00;
            out_reg              <= '0;
            req_reg              <= 1'b0;
            serial_output_line   <= 1'b0;
            serial_output_enable <= 1'b0;
            command              <= '0;
            command_valid        <= 1'b0;
            read_request         <= 1'b0;
            write_byte           <= 8'h00;
            write_strobe         <= 1'b0;
        end else begin
            state_reg            <= state_next;
            bit_reg              <= bit_next;
            fcnt_reg             <= fcnt_next;
            in_reg               <= in_next;
            out_reg              <= out_next;
            req_reg              <= req_next;
            serial_output_line   <= sdo_next;
            serial_output_enable <= oe_next;
            command              <= cmd_next;
            command_valid        <= cv_next;
            read_request         <= rr_next;
            write_byte           <= wb_next;
            write_strobe         <= ws_next;
        end
    end

endmodule

/* tb/spac_top_checker.sv */
// Purpose: Port-level assertions for the serial port and rate clocks.
// Assumes: Bound to spac_top; one clock domain, async high reset.
// Notes:   Two-wire frames are left out of the SPI quiet checks.
`timescale 1ns/1ps
module spac_top_checker (
    input wire logic                clock,
    input wire logic                reset,
    input wire logic                chip_select_n,
    input wire logic                serial_clock,
    input wire logic                hw_reset_n,
    input wire logic                serial_output_line,
    input wire logic                serial_output_enable,
    input wire spac_pkg::spac_cmd_t command,
    input wire logic                command_valid,
    input wire logic                read_request,
    input wire logic                write_strobe,
    input wire logic                two_wire_mode,
    input wire logic                analog_clock,
    input wire logic                data_ready_output
);
    import spac_pkg::*;
    logic       rd_seen_reg, rd_seen_next, wr_seen_reg, wr_seen_next;
    logic [2:0] pulse_cnt_reg, pulse_cnt_next;
    ////////////////////////////////////////////////////////////
    always_comb begin
        rd_seen_next = rd_seen_reg;
        wr_seen_next = wr_seen_reg;
        if (chip_select_n) begin
            rd_seen_next = 1'b0;
            wr_seen_next = 1'b0;
        end else if (command_valid) begin
            rd_seen_next = command.is_read;
            wr_seen_next = !command.is_read;
        end
        // Analog pulses seen while ready is low
        pulse_cnt_next = data_ready_output ? 3'h0 : pulse_cnt_reg + {2'h0, analog_clock};
    end
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rd_seen_reg   <= 1'b0;
            wr_seen_reg   <= 1'b0;
            pulse_cnt_reg <= 3'h0;
        end else begin
            rd_seen_reg   <= rd_seen_next;
            wr_seen_reg   <= wr_seen_next;
            pulse_cnt_reg <= pulse_cnt_next;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    property p_rise_stable; $rose(serial_clock) |=> $stable(serial_output_line)[*2]; endproperty
    a_rise_stable: assert property (p_rise_stable) else $error("output moved after rise");
    property p_cs_quiet; chip_select_n && $past(chip_select_n) && !two_wire_mode
        |-> !serial_output_enable; endproperty
    a_cs_quiet: assert property (p_cs_quiet) else $error("driven while deselected");
    property p_hw_quiet; !hw_reset_n && !$past(hw_reset_n) && !two_wire_mode
        |-> !serial_output_enable && !command_valid; endproperty
    a_hw_quiet: assert property (p_hw_quiet) else $error("active in hard reset");
    property p_write_quiet; wr_seen_reg |-> !serial_output_enable; endproperty
    a_write_quiet: assert property (p_write_quiet) else $error("driven in write");
    property p_read_only; $rose(serial_output_enable) && !two_wire_mode |-> rd_seen_reg;
    endproperty
    a_read_only: assert property (p_read_only) else $error("driven without read");
    property p_decode; command_valid |-> command.is_read == command.code[0]
        && read_request == command.is_read; endproperty
    a_decode: assert property (p_decode) else $error("command decode wrong");
    property p_cs_ignore; chip_select_n && $past(chip_select_n)
        |-> !command_valid && !write_strobe; endproperty
    a_cs_ignore: assert property (p_cs_ignore) else $error("input taken deselected");
    property p_dr_width; $rose(data_ready_output)
        |-> analog_clock && pulse_cnt_reg == 3'h2; endproperty
    a_dr_width: assert property (p_dr_width) else $error("ready pulse width wrong");
    c_read: cover property (command_valid && command.is_read);
    c_ready: cover property ($rose(data_ready_output));
    c_frame: cover property ($rose(serial_output_enable) && two_wire_mode);
endmodule

/* tb/spac_host_model.sv */
// Purpose: Host side of the serial link, mode 0 master.
// Assumes: Called from the bench just after a rising clock edge.
// Notes:   Released input line toggles, so stale bits never look valid.
`timescale 1ns/1ps
module spac_host_model (
    input  wire logic clock,
    input  wire logic serial_output_line,
    input  wire logic serial_output_enable,
    output logic      chip_select_n,
    output logic      serial_clock,
    output logic      serial_input_line,
    output logic [15:0] rx_bits
);
    initial begin
        chip_select_n = 1'b1;
        serial_clock = 1'b0;
        serial_input_line = 1'b0;
        rx_bits = 16'h0000;
    end
    ////////////////////////////////////////////////////////////
    // Three clocks a half period, above the two-clock minimum
    task automatic half(input logic level);
        serial_clock = level;
        if (level && serial_output_enable === 1'b1) begin
            rx_bits = {rx_bits[14:0], serial_output_line};
        end
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic strap(input logic v);
        serial_input_line = v;
    endtask
    task automatic run(input int n, input logic noisy);
        for (int i = 0; i < n; i++) begin
            if (noisy) serial_input_line = ~serial_input_line;
            half(1'b1);
            half(1'b0);
        end
    endtask
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] data);
        logic [15:0] word;
        word = {cmd, data};
        rx_bits = 16'h0000;
        chip_select_n = 1'b0;
        half(1'b0);
        for (int i = 15; i >= 0; i--) begin
            serial_input_line = word[i];
            half(1'b1);
            half(1'b0);
        end
        chip_select_n = 1'b1;
        serial_input_line = ~serial_input_line;
        half(1'b0);
    endtask
endmodule

/* tb/tb_spac_top.sv */
// Purpose: Self-checking bench for the serial port and rate clocks.
// Assumes: Crystal period 2 clocks, clock pin period 6 clocks.
// Notes:   Highest ratios left out to keep the run short.
`timescale 1ns/1ps
module tb_spac_top;
    import spac_pkg::*;
    localparam int LIMIT = 100000;
    logic clock, reset, hw_reset_n, mode_select_pin, master_reset, watchdog_reset;
    logic chip_select_n, serial_clock, serial_input_line, external_clock_select;
    logic crystal_clock = 1'b0, clock_input_pin = 1'b0, dr_prev = 1'b1;
    logic [1:0] prescale_field, ph = 2'h0;
    logic [2:0] ratio_select_field;
    logic [7:0] read_byte, write_byte, wr_seen;
    logic [15:0] frame_word, rx_bits, frame_seen;
    logic serial_output_line, serial_output_enable, command_valid, read_request;
    logic write_strobe, two_wire_mode, ratio_select_upper_pin, analog_clock;
    logic modulator_refresh, data_ready_output, sample_clock, output_rate_clock;
    spac_cmd_t command, cmd_seen;
    int cycles = 0, n_cmd = 0, n_wr = 0, n_drf = 0, mismatches = 0, comparisons = 0;
    spac_top #(.FRAME_W(16)) i_spac_top (.*);
    spac_host_model i_spac_host_model (.*);
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        #1;
        crystal_clock = ~crystal_clock;
        ph = (ph == 2'h2) ? 2'h0 : ph + 2'h1;
        if (ph == 2'h0) clock_input_pin = ~clock_input_pin;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        dr_prev <= data_ready_output;
        if (command_valid === 1'b1) begin
            cmd_seen <= command;
            n_cmd <= n_cmd + 1;
        end
        if (write_strobe === 1'b1) begin
            wr_seen <= write_byte;
            n_wr <= n_wr + 1;
        end
        if (dr_prev === 1'b1 && data_ready_output === 1'b0) n_drf <= n_drf + 1;
        if (cycles == LIMIT) begin
            mismatches++;
            finish_test();
        end
    end
    always @(negedge serial_output_enable) frame_seen = rx_bits;
    ////////////////////////////////////////////////////////////
    task automatic step();
        @(posedge clock);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_n(input string what, input int exp, input int got);
        comparisons++;
        if (got != exp) begin
            mismatches++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic wait_fall();
        int g = 0;
        do begin
            step();
            g++;
        end while (!(data_ready_output === 1'b0 && dr_prev === 1'b1) && g < 70000);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_idle();
        int n0 = n_cmd;
        chk("serial_output_enable", 16'h0000, {15'h0000, serial_output_enable});
        i_spac_host_model.run(20, 1'b1);
        chk_n("commands", n0, n_cmd);
    endtask
    task automatic t_write();
        int n0 = n_wr;
        i_spac_host_model.xfer(8'h42, 8'h5A);
        chk("command", 16'h0084, {7'h00, cmd_seen});
        chk_n("write_strobes", n0 + 1, n_wr);
        chk("write_byte", 16'h005A, {8'h00, wr_seen});
        chk("read_data", 16'h0000, rx_bits);
    endtask
    task automatic t_hw();
        int n0 = n_cmd;
        hw_reset_n = 1'b0;
        i_spac_host_model.xfer(8'h41, 8'h96);
        hw_reset_n = 1'b1;
        chk_n("commands", n0, n_cmd);
        chk("read_data", 16'h0000, rx_bits);
    endtask
    task automatic t_read();
        int n0 = n_wr;
        read_byte = 8'hA5;
        i_spac_host_model.xfer(8'h41, 8'h96);
        chk("command", 16'h0083, {7'h00, cmd_seen});
        chk("read_data", 16'h00A5, rx_bits);
        chk_n("write_strobes", n0, n_wr);
    endtask
    task automatic t_rate(input logic ext, input logic [1:0] pre, input logic [2:0] fld);
        int src = (ext ? 6 : 2) << pre, per = 0, lo = 0, nref = 0, sc = 0, rc = 0;
        external_clock_select = ext;
        prescale_field = pre;
        ratio_select_field = fld;
        wait_fall();
        wait_fall();
        do begin
            if (data_ready_output === 1'b0) lo++;
            if (modulator_refresh === 1'b1) nref++;
            if (sample_clock === 1'b1) sc++;
            if (output_rate_clock === 1'b1) rc++;
            step();
            per++;
        end while (!(data_ready_output === 1'b0 && dr_prev === 1'b1) && per < 70000);
        chk_n("rate_period", src * 4 * (32 << fld), per);
        chk_n("ready_low", src * 2, lo);
        chk_n("refreshes", 32 << fld, nref);
        chk_n("sample_high", src * 2 * (32 << fld), sc);
        chk_n("rate_high", src * 2 * (32 << fld), rc);
    endtask
    task automatic t_two_wire();
        int n0;
        frame_word = 16'hC3A5;
        ratio_select_field = 3'h0;
        prescale_field = 2'h0;
        i_spac_host_model.strap(1'b0);
        mode_select_pin = 1'b1;
        master_reset = 1'b1;
        step();
        master_reset = 1'b0;
        repeat (3) step();
        chk("two_wire_mode", 16'h0001, {15'h0000, two_wire_mode});
        chk("upper_ratio", 16'h0000, {15'h0000, ratio_select_upper_pin});
        n0 = n_drf;
        i_spac_host_model.run(300, 1'b0);
        chk("frame", 16'hC3A5, frame_seen);
        chk_n("ready_falls", n0, n_drf);
        i_spac_host_model.strap(1'b1);
        watchdog_reset = 1'b1;
        step();
        watchdog_reset = 1'b0;
        repeat (3) step();
        chk("upper_ratio", 16'h0001, {15'h0000, ratio_select_upper_pin});
    endtask
    initial begin
        reset = 1'b1;
        hw_reset_n = 1'b1;
        mode_select_pin = 1'b0;
        master_reset = 1'b0;
        watchdog_reset = 1'b0;
        external_clock_select = 1'b0;
        prescale_field = 2'h0;
        ratio_select_field = 3'h3;
        read_byte = 8'h00;
        frame_word = 16'h0000;
        repeat (6) @(posedge clock);
        #1;
        reset = 1'b0;
        repeat (2) step();
        chk("two_wire_mode", 16'h0000, {15'h0000, two_wire_mode});
        t_idle();
        t_write();
        t_hw();
        t_read();
        for (int f = 0; f < 6; f++) t_rate(1'b0, 2'h0, f[2:0]);
        t_rate(1'b1, 2'h1, 3'h0);
        t_rate(1'b0, 2'h2, 3'h0);
        t_rate(1'b0, 2'h3, 3'h0);
        t_two_wire();
        finish_test();
    end
endmodule
bind spac_top spac_top_checker i_spac_top_checker (.*);
